//--- logic/adrr_consts.vh
// Constants for the result-delivery and conversion-control block.
// Included by the formatter, the top level and the bench; holds definitions only.
`ifndef ADRR_CONSTS_VH
`define ADRR_CONSTS_VH

// ****************************************************************
// APB register byte offsets
// ****************************************************************
`define ADRR_OFS_CTRL 8'h00
`define ADRR_OFS_STATUS 8'h04
`define ADRR_OFS_RESULT 8'h08
`define ADRR_OFS_IRQ_STAT 8'h0c
`define ADRR_OFS_IRQ_MASK 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define ADRR_CTRL_CHOP_BIT 0
`define ADRR_CTRL_CHAN_LSB 1
`define ADRR_CTRL_CHAN_MSB 5
`define ADRR_STAT_NEW_BIT 7
`define ADRR_STAT_CLIP_BIT 6
`define ADRR_STAT_SUPPLY_BIT 5
`define ADRR_IRQ_RESULT_BIT 0
`define ADRR_IRQ_SUPPLY_BIT 1
`define ADRR_IRQ_CLIP_BIT 2
`define ADRR_IRQ_W 3

// ****************************************************************
// Reset values
// ****************************************************************
`define ADRR_CTRL_RST 6'h00
`define ADRR_IRQ_MASK_RST 3'h0

// ****************************************************************
// Serial command codes (top three bits of the command byte)
// ****************************************************************
`define ADRR_CMD_READ 3'h1
`define ADRR_CMD_PULSE 3'h4

// ****************************************************************
// Result coding
// ****************************************************************
`define ADRR_CODE_MAX 24'h7fffff
`define ADRR_CODE_MIN 24'h800000
`define ADRR_CODE_POS_REF 24'h780000
`define ADRR_CODE_NEG_REF 24'h87ffff
`define ADRR_CODE_ZERO 24'h000000

// ****************************************************************
// Internal monitor channel numbers
// ****************************************************************
`define ADRR_CH_OFFSET 5'h18
`define ADRR_CH_SUPPLY 5'h19
`define ADRR_CH_TEMP 5'h1a
`define ADRR_CH_GAIN 5'h1b
`define ADRR_CH_REF 5'h1c

// ****************************************************************
// Supply trip codes: volts times 786432, 4.3 V and 4.35 V
// ****************************************************************
`define ADRR_SUPPLY_TRIP 24'h3399a2
`define ADRR_SUPPLY_CLEAR 24'h343333

// ****************************************************************
// Timing
// ****************************************************************
`define ADRR_CONV_CYCLES 80

`endif

//--- logic/adrr_sync.v
// Two-flop synchroniser for a bundle of independent pin levels.
// Assumes each bit is a slow level or a clock far slower than clk_in.
`timescale 1ns/1ps

module adrr_sync
#(
  parameter W = 1
)
(
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // Asynchronous pins in, synchronous levels out
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  // First stage, read only by the second stage
  reg [W-1:0] meta_r;

  // ****************************************************************
  // Two stages, both cleared by reset
  // ****************************************************************
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      meta_r <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

//--- logic/adrr_code_fmt.v
// Result formatter: saturates a wide filter value to 24-bit code.
// Assumes raw_in is in code steps (reference / 780000h) from the filter.
`timescale 1ns/1ps
`include "adrr_consts.vh"

module adrr_code_fmt
#(
  parameter RAW_W = 26
)
(
  // Filter value and its channel
  input wire signed [RAW_W-1:0] raw_in,
  input wire [4:0] chan_in,
  // Supply state from the trip comparator
  input wire supply_low_in,
  // Formatted code and clip flag
  output reg [23:0] code_out,
  output reg clip_out
);

  // Saturation bounds widened to the filter width
  wire signed [RAW_W-1:0] max_w = $signed({{(RAW_W-24){1'b0}}, `ADRR_CODE_MAX});
  wire signed [RAW_W-1:0] min_w = $signed({{(RAW_W-24){1'b1}}, `ADRR_CODE_MIN});

  // ****************************************************************
  // Clip, then force the supply reading to zero while the supply is flagged low
  // ****************************************************************
  always @*
  begin
    clip_out = 1'b0;
    if (raw_in > max_w)
    begin
      code_out = `ADRR_CODE_MAX;
      clip_out = 1'b1;
    end
    else if (raw_in < min_w)
    begin
      code_out = `ADRR_CODE_MIN;
      clip_out = 1'b1;
    end
    else
    begin
      code_out = raw_in[23:0];
    end
    if (chan_in == `ADRR_CH_SUPPLY && supply_low_in)
    begin
      code_out = `ADRR_CODE_ZERO;
      clip_out = 1'b0;
    end
  end

endmodule

//--- logic/adrr_top.v
// Result delivery and conversion control of a multichannel converter.
// Assumes the filter and supply codes arrive on clk_in; serial pins and
// the start pin are asynchronous and are synchronised here.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "adrr_consts.vh"

module adrr_top
#(
  parameter RAW_W = 26,
  parameter CONV_CYCLES = `ADRR_CONV_CYCLES
)
(
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // Serial port pins
  input wire sclk_in,
  input wire cs_n_in,
  input wire mosi_in,
  output reg miso_out,
  output reg miso_oe_out,
  // Conversion control pin
  input wire start_in,
  // Filter result and supply measurement, on clk_in
  input wire signed [RAW_W-1:0] raw_data_in,
  input wire [23:0] supply_code_in,
  // Front-end control
  output reg [4:0] mux_sel_out,
  output reg chop_en_out,
  output reg conv_active_out,
  // Result ready pin and interrupt
  output reg result_ready_n_out,
  output reg irq_out
);

  // ****************************************************************
  // State codes
  // ****************************************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  // Synchronised pins: start, mosi, select (inverted), sclk
  wire [3:0] pins_s;
  wire start_s = pins_s[3];
  wire mosi_s = pins_s[2];
  // Select travels inverted so the cleared flops read as deselected
  wire cs_n_s = ~pins_s[1];
  wire sclk_s = pins_s[0];
  // Previous sclk for edge finding
  reg sclk_d_r;
  wire sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;

  // Serial shifter state
  reg [7:0] cmd_r;
  reg [3:0] bitcnt_r;
  reg [31:0] shout_r;
  reg cmd_done_r;
  reg pulse_req_r;

  // Conversion engine
  reg state_r;
  reg [15:0] cnt_r;
  wire conv_done = (state_r == ST_CONV) && (cnt_r == 16'h0000);

  // Result and flags
  reg [23:0] result_r;
  reg [4:0] res_chan_r;
  reg new_r;
  reg clip_r;
  reg supply_low_r;
  reg pend_r;

  // Register file
  reg [5:0] ctrl_r;
  reg [`ADRR_IRQ_W-1:0] irq_stat_r;
  reg [`ADRR_IRQ_W-1:0] irq_mask_r;

  // Formatter outputs
  wire [23:0] code_w;
  wire clip_w;

  // Status byte seen by both the serial read and the APB
  wire [7:0] status_byte = {new_r, clip_r, supply_low_r, res_chan_r};

  // ****************************************************************
  // Submodules
  // ****************************************************************
  adrr_sync #(.W(4)) u_sync
  (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .async_in({start_in, mosi_in, ~cs_n_in, sclk_in}),
    .sync_out(pins_s)
  );

  adrr_code_fmt #(.RAW_W(RAW_W)) u_fmt
  (
    .raw_in(raw_data_in),
    .chan_in(mux_sel_out),
    .supply_low_in(supply_low_r),
    .code_out(code_w),
    .clip_out(clip_w)
  );

  // ****************************************************************
  // Serial port: mosi taken on rising edges, miso moves on falling
  // ****************************************************************
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      sclk_d_r <= 1'b0;
      cmd_r <= 8'h00;
      bitcnt_r <= 4'h0;
      shout_r <= 32'h00000000;
      cmd_done_r <= 1'b0;
      pulse_req_r <= 1'b0;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      pulse_req_r <= 1'b0;
      // Drive miso only while selected
      miso_oe_out <= ~cs_n_s;
      if (cs_n_s)
      begin
        // Deselect aborts any half-shifted byte
        bitcnt_r <= 4'h0;
        cmd_done_r <= 1'b0;
        miso_out <= 1'b0;
      end
      else
      begin
        if (sclk_rise && !cmd_done_r)
        begin
          cmd_r <= {cmd_r[6:0], mosi_s};
        end
        if (sclk_fall)
        begin
          if (!cmd_done_r && bitcnt_r == 4'h7)
          begin
            cmd_done_r <= 1'b1;
            if (cmd_r[7:5] == `ADRR_CMD_PULSE)
            begin
              pulse_req_r <= 1'b1;
            end
            if (cmd_r[7:5] == `ADRR_CMD_READ)
            begin
              shout_r <= {status_byte[6:0], result_r, 1'b0};
              miso_out <= status_byte[7];
            end
          end
          else if (cmd_done_r)
          begin
            miso_out <= shout_r[31];
            shout_r <= {shout_r[30:0], 1'b0};
          end
          if (!cmd_done_r)
          begin
            bitcnt_r <= bitcnt_r + 4'h1;
          end
        end
      end
    end
  end

  // Read command decoded in this cycle
  wire read_taken = sclk_fall && !cmd_done_r && bitcnt_r == 4'h7 &&
                    cmd_r[7:5] == `ADRR_CMD_READ;

  // ****************************************************************
  // Conversion engine
  // ****************************************************************
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      conv_active_out <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start_s || pulse_req_r)
          begin
            state_r <= ST_CONV;
            cnt_r <= CONV_CYCLES[15:0] - 16'h0001;
            conv_active_out <= 1'b1;
          end
        end
        ST_CONV:
        begin
          if (cnt_r != 16'h0000)
          begin
            // Pulse requests mid-conversion are ignored
            cnt_r <= cnt_r - 16'h0001;
          end
          else if (start_s)
          begin
            // Continuous conversion while start stays high
            cnt_r <= CONV_CYCLES[15:0] - 16'h0001;
          end
          else
          begin
            state_r <= ST_IDLE;
            conv_active_out <= 1'b0;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
          conv_active_out <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Result capture, new flag and the ready pin
  // ****************************************************************
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      result_r <= 24'h000000;
      res_chan_r <= 5'h00;
      new_r <= 1'b0;
      clip_r <= 1'b0;
      pend_r <= 1'b0;
      result_ready_n_out <= 1'b1;
    end
    else
    begin
      pend_r <= 1'b0;
      if (conv_done)
      begin
        result_r <= code_w;
        res_chan_r <= mux_sel_out;
        clip_r <= clip_w;
        new_r <= 1'b1;
        if (!result_ready_n_out)
        begin
          result_ready_n_out <= 1'b1;
          pend_r <= 1'b1;
        end
        else
        begin
          result_ready_n_out <= 1'b0;
        end
      end
      else
      begin
        if (read_taken)
        begin
          new_r <= 1'b0;
        end
        if (pend_r)
        begin
          result_ready_n_out <= 1'b0;
        end
        else if (sclk_fall)
        begin
          result_ready_n_out <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Supply trip with hysteresis
  // ****************************************************************
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      supply_low_r <= 1'b0;
    end
    else if (supply_code_in < `ADRR_SUPPLY_TRIP)
    begin
      supply_low_r <= 1'b1;
    end
    else if (supply_code_in >= `ADRR_SUPPLY_CLEAR)
    begin
      supply_low_r <= 1'b0;
    end
  end

  // ****************************************************************
  // APB slave: answer one cycle into the access phase
  // ****************************************************************
  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in & pready_out;
  wire addr_ok = paddr_in == `ADRR_OFS_CTRL || paddr_in == `ADRR_OFS_STATUS ||
                 paddr_in == `ADRR_OFS_RESULT || paddr_in == `ADRR_OFS_IRQ_STAT ||
                 paddr_in == `ADRR_OFS_IRQ_MASK;
  // Interrupt events of this cycle
  wire [`ADRR_IRQ_W-1:0] irq_ev = {conv_done & clip_w,
                                   conv_done ? 1'b0 : 1'b0,
                                   conv_done};
  // Rising supply trip counts as its own event
  wire supply_ev = (supply_code_in < `ADRR_SUPPLY_TRIP) & ~supply_low_r;

  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      prdata_out <= 32'h00000000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      ctrl_r <= `ADRR_CTRL_RST;
      irq_mask_r <= `ADRR_IRQ_MASK_RST;
      irq_stat_r <= {`ADRR_IRQ_W{1'b0}};
    end
    else
    begin
      pready_out <= setup;
      pslverr_out <= setup & ~addr_ok;
      if (setup)
      begin
        case (paddr_in)
          `ADRR_OFS_CTRL: prdata_out <= {26'h0000000, ctrl_r};
          `ADRR_OFS_STATUS: prdata_out <= {23'h000000, conv_active_out, status_byte};
          `ADRR_OFS_RESULT: prdata_out <= {8'h00, result_r};
          `ADRR_OFS_IRQ_STAT: prdata_out <= {29'h00000000, irq_stat_r};
          `ADRR_OFS_IRQ_MASK: prdata_out <= {29'h00000000, irq_mask_r};
          default: prdata_out <= 32'h00000000;
        endcase
      end
      if (access && pwrite_in && paddr_in == `ADRR_OFS_CTRL)
      begin
        ctrl_r <= pwdata_in[5:0];
      end
      if (access && pwrite_in && paddr_in == `ADRR_OFS_IRQ_MASK)
      begin
        irq_mask_r <= pwdata_in[`ADRR_IRQ_W-1:0];
      end
      // Read clears only the bits it returned; later events still land
      if (access && !pwrite_in && paddr_in == `ADRR_OFS_IRQ_STAT)
      begin
        irq_stat_r <= (irq_stat_r & ~prdata_out[`ADRR_IRQ_W-1:0]) |
                      irq_ev | {1'b0, supply_ev, 1'b0};
      end
      else
      begin
        irq_stat_r <= irq_stat_r | irq_ev | {1'b0, supply_ev, 1'b0};
      end
    end
  end

  // ****************************************************************
  // Registered front-end controls and interrupt line
  // ****************************************************************
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      mux_sel_out <= 5'h00;
      chop_en_out <= 1'b0;
      irq_out <= 1'b0;
    end
    else
    begin
      // Channel only moves between conversions, so results match it
      if (state_r == ST_IDLE)
      begin
        mux_sel_out <= ctrl_r[`ADRR_CTRL_CHAN_MSB:`ADRR_CTRL_CHAN_LSB];
      end
      // Software must clear chop before picking a monitor channel
      chop_en_out <= ctrl_r[`ADRR_CTRL_CHOP_BIT];
      irq_out <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

//--- dv/adrr_top_props.sv
// Checker of the result-delivery block, bound to its top module.
// Assumes pins move far slower than clk_in; sees top ports only.
`timescale 1ns/1ps
module adrr_top_props
#(
  parameter CONV_CYCLES = 80
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Serial, start and status pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic start_in,
  input wire logic miso_oe_out,
  input wire logic conv_active_out,
  input wire logic result_ready_n_out,
  input wire logic irq_out
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // Stop bound: two conversion lengths plus 8 cycles, above start sync lag plus one conversion just begun
  localparam int LIM = 2 * CONV_CYCLES + 8;
  logic sclk_d_r; // Last sampled serial clock
  logic fell_r; // A falling serial edge seen in this frame
  int idle_r; // Cycles with start low and no frame open
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Track frame edges and idle time; counter saturates
  always @(posedge clk_in)
  begin
    sclk_d_r <= sclk_in;
    fell_r <= !srst_in && !cs_n_in && (fell_r || (sclk_d_r && !sclk_in));
    idle_r <= (srst_in || start_in || !cs_n_in) ? 0 : ((idle_r < 1000) ? idle_r + 1 : idle_r);
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_rst;
    $fell(srst_in) |-> result_ready_n_out && !irq_out && !conv_active_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_done;
    $fell(conv_active_out) |-> ##[0:3] !result_ready_n_out;
  endproperty
  a_done: assert property (p_done) else $error("no ready after conversion");
  property p_first_fall;
    !cs_n_in && sclk_d_r && !sclk_in && !fell_r |-> ##[1:6] result_ready_n_out;
  endproperty
  a_first_fall: assert property (p_first_fall) else $error("ready kept low");
  property p_pulse;
    $rose(result_ready_n_out) && cs_n_in |=> !result_ready_n_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("overwrite pulse too long");
  property p_stop;
    idle_r > LIM |-> !conv_active_out;
  endproperty
  a_stop: assert property (p_stop) else $error("converting with start low");
  property p_apb_rdy;
    psel_in && !penable_in |=> pready_out;
  endproperty
  a_apb_rdy: assert property (p_apb_rdy) else $error("no ready in access phase");
  property p_unmapped;
    psel_in && !penable_in && paddr_in > 8'h10 |=> pslverr_out && prdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_oe_off;
    cs_n_in [*5] |-> !miso_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");
  // Main scenarios reached
  c_ready: cover property ($fell(result_ready_n_out));
  c_pulse: cover property ($rose(result_ready_n_out) && cs_n_in);
  c_err: cover property (pslverr_out);
endmodule
bind adrr_top adrr_top_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (
  .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
  .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .start_in(start_in),
  .miso_oe_out(miso_oe_out), .conv_active_out(conv_active_out),
  .result_ready_n_out(result_ready_n_out), .irq_out(irq_out));

//--- dv/adrr_host.sv
// Host model on the serial port: sends command frames, reads replies.
// Assumes the block samples on rising and shifts on falling edges.
`timescale 1ns/1ps
module adrr_host
(
  // Serial pins toward the block
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  // Clock idles low and stands still between frames
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // One frame, 800 ns clock, phase offset from the system clock
  task automatic frame(input logic [7:0] cmd, input int nrd, output logic [31:0] rx);
    rx = 32'h0;
    #37 cs_n_out = 1'b0;
    #400;
    for (int i = 0; i < 8 + nrd; i++)
    begin
      mosi_out = (i < 8) ? cmd[7 - i] : 1'b0;
      #400 sclk_out = 1'b1;
      rx = (i < 8) ? rx : {rx[30:0], miso_in};
      #400 sclk_out = 1'b0;
    end
    #400 cs_n_out = 1'b1;
    // Released line shows no stale level
    mosi_out = ~mosi_out;
  endtask
endmodule

//--- dv/adc_data_ready_and_readback_bench.sv
// Self-checking bench: APB master tasks and a host model on the pins.
// Assumes the design, its include path and the host model are compiled.
`timescale 1ns/1ps
`include "adrr_consts.vh"
module adc_data_ready_and_readback_bench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int CONV = 8; // Short conversion keeps the run brief
  logic clk_in = 1'b0, srst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, start_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic signed [25:0] raw_data_in = 26'h0;
  logic [23:0] supply_code_in = 24'h3c0000;
  logic pready_out, pslverr_out, sclk, cs_n, mosi, miso_out, miso_oe_out;
  logic conv_active_out, result_ready_n_out, irq_out, chop_en_out;
  logic [4:0] mux_sel_out;
  int miscompares = 0, checks_done = 0;
  // Filter values, expected codes, supply steps
  logic [25:0] raw_t [5] = '{26'h0780000, 26'h0, 26'h387ffff, 26'h0900000, 26'h3700000};
  logic [23:0] code_t [5] = '{24'h780000, 24'h0, 24'h87ffff, 24'h7fffff, 24'h800000};
  logic [23:0] sup_t [4] = '{24'h3c0000, 24'h300000, 24'h340000, 24'h350000};
  logic [23:0] sres_t [4] = '{24'h3c0000, 24'h0, 24'h0, 24'h350000};
  always #50 clk_in = ~clk_in;
  adrr_top #(.CONV_CYCLES(CONV)) u_adrr_top (
    .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso_out),
    .miso_oe_out(miso_oe_out), .start_in(start_in), .raw_data_in(raw_data_in),
    .supply_code_in(supply_code_in), .mux_sel_out(mux_sel_out), .chop_en_out(chop_en_out),
    .conv_active_out(conv_active_out), .result_ready_n_out(result_ready_n_out),
    .irq_out(irq_out));
  adrr_host host_m (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso_out));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer; pready and data taken at a rising edge, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1)
    begin
      chk("apb ready timeout", 32'h1, 32'h0);
      summarize();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(nm, d & m, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // Bounded wait for a level on the ready pin
  task automatic wait_rdy(input logic v);
    int n;
    n = 0;
    while (result_ready_n_out !== v && n < 300)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 300)
    begin
      chk("ready wait timeout", 32'h1, 32'h0);
      summarize();
    end
  endtask
  // Pulse-convert command with start low; waits for the new result
  task automatic conv1(input logic [25:0] raw);
    logic [31:0] rx;
    @(posedge clk_in);
    raw_data_in <= raw;
    fork
      host_m.frame({`ADRR_CMD_PULSE, 5'h00}, 0, rx);
      begin
        wait_rdy(1'b1);
        wait_rdy(1'b0);
      end
    join
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] d;
    logic e;
    chk("ready pin", result_ready_n_out, 32'h1);
    rchk("status new", `ADRR_OFS_STATUS, 32'h80, 32'h0);
    rchk("ctrl", `ADRR_OFS_CTRL, 32'hffffffff, {26'h0, `ADRR_CTRL_RST});
    rchk("irq mask", `ADRR_OFS_IRQ_MASK, 32'hffffffff, {29'h0, `ADRR_IRQ_MASK_RST});
    apb(1'b0, 8'h40, 32'h0, d, e);
    chk("unmapped err", e, 32'h1);
    chk("unmapped data", d, 32'h0);
  endtask
  // Codes at full scale, zero and both overloads; unread results overwritten
  task automatic t_coding();
    for (int i = 0; i < 5; i++)
    begin
      conv1(raw_t[i]);
      rchk("code", `ADRR_OFS_RESULT, 32'hffffffff, {8'h0, code_t[i]});
      rchk("new clip", `ADRR_OFS_STATUS, 32'hc0, (i > 2) ? 32'hc0 : 32'h80);
      repeat (3 * CONV) @(negedge clk_in);
      chk("one conversion", conv_active_out, 32'h0);
      chk("ready held", result_ready_n_out, 32'h0);
      chk("irq masked", irq_out, 32'h0);
    end
  endtask
  task automatic t_serial();
    logic [31:0] rx;
    conv1(26'h0123456);
    fork
      host_m.frame({`ADRR_CMD_READ, 5'h00}, 32, rx);
      begin
        @(negedge sclk);
        repeat (6) @(negedge clk_in);
        chk("ready after fall", result_ready_n_out, 32'h1);
      end
    join
    chk("serial new", rx[31], 32'h1);
    chk("serial code", rx[23:0], 32'h123456);
    rchk("new cleared", `ADRR_OFS_STATUS, 32'h80, 32'h0);
  endtask
  // Start high runs on; dropping it mid-conversion finishes that one
  task automatic t_continuous();
    logic hi;
    @(posedge clk_in);
    raw_data_in <= 26'h0000100;
    start_in <= 1'b1;
    wait_rdy(1'b0);
    wait_rdy(1'b1);
    @(negedge clk_in);
    chk("overwrite pulse", result_ready_n_out, 32'h0);
    @(posedge clk_in);
    start_in <= 1'b0;
    wait_rdy(1'b1);
    @(negedge clk_in);
    hi = 1'b0;
    repeat (4 * CONV)
    begin
      @(negedge clk_in);
      hi = hi | result_ready_n_out;
    end
    chk("no result after stop", hi, 32'h0);
    chk("idle", conv_active_out, 32'h0);
  endtask
  // Supply channel, trip, hysteresis and the supply interrupt
  task automatic t_supply();
    wr(`ADRR_OFS_CTRL, {26'h0, `ADRR_CH_SUPPLY, 1'b0});
    wr(`ADRR_OFS_IRQ_MASK, 32'h2);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_in);
      supply_code_in <= sup_t[i];
      conv1({2'b00, sup_t[i]});
      chk("chop", chop_en_out, 32'h0);
      chk("mux", mux_sel_out, {27'h0, `ADRR_CH_SUPPLY});
      rchk("supply", `ADRR_OFS_RESULT, 32'hffffffff, {8'h0, sres_t[i]});
      rchk("low flag", `ADRR_OFS_STATUS, 32'h20, (i == 1 || i == 2) ? 32'h20 : 32'h0);
      chk("irq level", irq_out, (i == 1) ? 32'h1 : 32'h0);
      rchk("irq stat", `ADRR_OFS_IRQ_STAT, 32'h2, (i == 1) ? 32'h2 : 32'h0);
      repeat (2) @(negedge clk_in);
      chk("irq cleared", irq_out, 32'h0);
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_coding();
    t_serial();
    t_continuous();
    t_supply();
    summarize();
  end
endmodule
